// ---- hdl/dcpma_consts.svh ----
// address map, frame byte counts and field constants for the control port
`ifndef DCPMA_CONSTS_SVH
`define DCPMA_CONSTS_SVH
// region bounds, 12-bit target address
`define DCPMA_COEF_LAST   12'h3ff
`define DCPMA_INSTR_LAST  12'h7ff
`define DCPMA_IFACE_LAST  12'h807
`define DCPMA_GPIO_LAST   12'h80c
`define DCPMA_SLD_FIRST   12'h810
`define DCPMA_SLD_LAST    12'h814
`define DCPMA_SLA_FIRST   12'h815
`define DCPMA_SLA_LAST    12'h819
`define DCPMA_CAP0        12'h81a
`define DCPMA_CAP1        12'h81b
`define DCPMA_CORE_CTRL   12'h81c
`define DCPMA_SOUT0       12'h81e
`define DCPMA_SOUT1       12'h81f
`define DCPMA_SIN         12'h820
`define DCPMA_RAMCFG      12'h821
// data bytes per word
`define DCPMA_NB_COEF     3'h4
`define DCPMA_NB_INSTR    3'h5
`define DCPMA_NB_REG16    3'h2
`define DCPMA_NB_REG8     3'h1
`define DCPMA_NB_CAP_RD   3'h3
`define DCPMA_NB_SLOT     3'h5
// zero pad above a 28-bit coefficient
`define DCPMA_COEF_PAD    4'h0
// reset value of the core and serial-out registers
`define DCPMA_REG_RESET   16'h0000
`endif

// ---- hdl/dcpma_pkg.sv ----
// types shared by the control port logic
package dcpma_pkg;
  typedef enum logic [2:0] {ST_IDLE, ST_AHI, ST_ALO, ST_DATA, ST_SKIP} dcpma_state_type;
  typedef logic [11:0] dcpma_addr_type;
  typedef logic [39:0] dcpma_word_type;
endpackage

// ---- hdl/dcpma_top.sv ----
// control port frame decoder with coefficient/instruction RAMs and registers
`include "dcpma_consts.svh"
//
// Contract
// RULE_01 - coefficient RAM 1024x32 at 0x000-0x3ff
// RULE_02 - instruction RAM 1024x40 at 0x400-0x7ff, direct
// RULE_03 - power-up zero, instruction RAM holds default
// RULE_04 - coefficient 28 bits, four zero pad bits
// RULE_05 - direct coefficient write steals RAM from core
// RULE_06 - host clears registers bit while loading
// RULE_07 - five slots, copied only when RAM idle
// RULE_08 - slots target coefficient RAM only
// RULE_09 - audio data RAM never addressable
// RULE_10 - three header bytes; address sets byte count
// RULE_11 - data zero-extended to whole bytes
// RULE_12 - stop or latch high ends frame
// RULE_13 - burst auto-increments across region boundaries
// RULE_14 - coefficient frame: 2 address, 4 data bytes
// RULE_15 - instruction frame: 2 address, 5 data bytes
// RULE_16 - core and serial-out registers two bytes
// RULE_17 - RAM config and serial-in one byte
// RULE_18 - capture write: program count and source
// RULE_19 - capture read returns three bytes
// RULE_20 - slot address write two bytes
// RULE_21 - slot data write five bytes
// RULE_22 - capture registers at 0x81a and 0x81b
// RULE_23 - unmapped: writes ignored, reads zero
module dcpma_top
  import dcpma_pkg::*;
#(
  parameter logic [6:0]  DEV_ADDR      = 7'h34,          // arbitrary select address
  parameter int          SLOTS         = 5,              // deferred update slots
  parameter logic [39:0] INSTR_DEFAULT = 40'h0000000000  // default program word
) (
  input  wire logic        MCLK,
  input  wire logic        SRST,
  input  wire logic        BYTE_VALID,
  input  wire logic [7:0]  BYTE_DATA,
  input  wire logic        FRAME_END,
  output logic      [7:0]  RD_DATA,
  output logic             RD_VALID,
  input  wire logic        RAM_IDLE,
  input  wire logic [9:0]  CORE_COEF_ADDR,
  output logic      [31:0] CORE_COEF_DATA,
  input  wire logic [9:0]  CORE_INSTR_ADDR,
  output logic      [39:0] CORE_INSTR_DATA,
  output logic             COEF_RAM_STOLEN,
  input  wire logic [23:0] CAPTURE_VALUE_0,
  input  wire logic [23:0] CAPTURE_VALUE_1,
  output logic      [10:0] CAPTURE_PROGRAM_COUNT_0,
  output logic      [1:0]  CAPTURE_SOURCE_SELECT_0,
  output logic      [10:0] CAPTURE_PROGRAM_COUNT_1,
  output logic      [1:0]  CAPTURE_SOURCE_SELECT_1,
  output logic      [15:0] CORE_CONTROL,
  output logic      [15:0] SERIAL_OUT_0,
  output logic      [15:0] SERIAL_OUT_1,
  output logic      [7:0]  SERIAL_IN_CTRL,
  output logic      [7:0]  RAM_CONFIG
);
  default clocking dcpma_cb @(posedge MCLK); endclocking
  default disable iff (SRST);
  // memories; power-up contents only, reset leaves them alone
  logic [31:0] coef_ram  [1024] = '{default: 32'h00000000};  // RULE_03
  logic [39:0] instr_ram [1024] = '{default: INSTR_DEFAULT}; // RULE_03
  // frame state
  dcpma_state_type state_ff, nxt_state;        // frame position
  logic            rnw_ff, nxt_rnw;            // read frame
  dcpma_addr_type  addr_ff, nxt_addr;          // target address
  logic [2:0]      cnt_ff, nxt_cnt;            // byte within word
  logic [31:0]     sr_ff, nxt_sr;              // collected bytes
  logic [7:0]      rd_data_ff, nxt_rd_data;    // byte returned
  logic            rd_valid_ff, nxt_rd_valid;  // return strobe
  // registers
  logic [15:0] core_ff, nxt_core;              // core control
  logic [15:0] sout0_ff, nxt_sout0;            // serial out 0
  logic [15:0] sout1_ff, nxt_sout1;            // serial out 1
  logic [7:0]  sin_ff, nxt_sin;                // serial in
  logic [7:0]  ramcfg_ff, nxt_ramcfg;          // RAM config
  logic [12:0] cap0_ff, nxt_cap0;              // capture setup 0
  logic [12:0] cap1_ff, nxt_cap1;              // capture setup 1
  logic [9:0]  sla_ff [SLOTS], nxt_sla [SLOTS]; // slot addresses
  logic [27:0] sld_ff [SLOTS], nxt_sld [SLOTS]; // slot data
  logic [SLOTS-1:0] pend_ff, nxt_pend;         // slots awaiting copy
  // staged direct coefficient write
  logic        stolen_ff, nxt_stolen;          // RAM held from core
  logic [9:0]  swa_ff, nxt_swa;                // staged address
  logic [27:0] swd_ff, nxt_swd;                // staged data
  // decode helpers
  logic [2:0]     nb;                          // bytes per word
  logic           last;                        // final byte of word
  logic           commit;                      // write word complete
  dcpma_word_type wword;                       // assembled write word
  dcpma_word_type rd_word;                     // word being read
  logic [2:0]     idx;                         // byte index from bottom
  logic [2:0]     sl_idx;                      // slot from address
  logic           sl_fire;                     // slot copy this cycle
  logic [2:0]     sl_sel;                      // lowest pending slot
  // data bytes that follow the header for an address
  function automatic logic [2:0] nbytes(input dcpma_addr_type a, input logic rd);
    logic [2:0] n = `DCPMA_NB_REG8;            // RULE_23
    if (a <= `DCPMA_COEF_LAST) n = `DCPMA_NB_COEF;        // RULE_14
    else if (a <= `DCPMA_INSTR_LAST) n = `DCPMA_NB_INSTR; // RULE_15
    else if (a <= `DCPMA_IFACE_LAST) n = `DCPMA_NB_COEF;
    else if (a <= `DCPMA_GPIO_LAST) n = `DCPMA_NB_REG16;
    else if (a >= `DCPMA_SLD_FIRST && a <= `DCPMA_SLD_LAST) n = `DCPMA_NB_SLOT;  // RULE_21
    else if (a >= `DCPMA_SLA_FIRST && a <= `DCPMA_SLA_LAST) n = `DCPMA_NB_REG16; // RULE_20
    else if (a == `DCPMA_CAP0 || a == `DCPMA_CAP1)
      n = rd ? `DCPMA_NB_CAP_RD : `DCPMA_NB_REG16;        // RULE_18 RULE_19
    else if (a == `DCPMA_CORE_CTRL || a == `DCPMA_SOUT0 || a == `DCPMA_SOUT1)
      n = `DCPMA_NB_REG16;                     // RULE_16
    else if (a == `DCPMA_SIN || a == `DCPMA_RAMCFG) n = `DCPMA_NB_REG8; // RULE_17
    return n;
  endfunction
  assign nb     = nbytes(addr_ff, rnw_ff);   // RULE_10
  assign last   = (cnt_ff == 3'(nb - 3'h1));
  assign commit = BYTE_VALID && !FRAME_END && (state_ff == ST_DATA) && !rnw_ff && last;
  assign wword  = {sr_ff, BYTE_DATA};        // RULE_11
  assign idx    = 3'(nb - 3'h1 - cnt_ff);
  assign sl_idx = 3'(addr_ff - `DCPMA_SLD_FIRST);
  // word seen by a read; unmapped and data RAM space read zero
  always_comb begin
    rd_word = 40'h0000000000;
    if (addr_ff <= `DCPMA_COEF_LAST) begin
      rd_word = {8'h00, coef_ram[addr_ff[9:0]]};          // RULE_01
    end else if (addr_ff <= `DCPMA_INSTR_LAST) begin
      rd_word = instr_ram[addr_ff[9:0]];                  // RULE_02
    end else begin
      case (addr_ff)
        `DCPMA_CAP0:      rd_word = {16'h0000, CAPTURE_VALUE_0}; // RULE_19 RULE_22
        `DCPMA_CAP1:      rd_word = {16'h0000, CAPTURE_VALUE_1}; // RULE_19 RULE_22
        `DCPMA_CORE_CTRL: rd_word = {24'h000000, core_ff};
        `DCPMA_SOUT0:     rd_word = {24'h000000, sout0_ff};
        `DCPMA_SOUT1:     rd_word = {24'h000000, sout1_ff};
        `DCPMA_SIN:       rd_word = {32'h00000000, sin_ff};
        `DCPMA_RAMCFG:    rd_word = {32'h00000000, ramcfg_ff};
        default:          rd_word = 40'h0000000000;       // RULE_09 RULE_23
      endcase
    end
  end
  // frame walker: header, address, data bytes
  always_comb begin
    nxt_state    = state_ff;
    nxt_rnw      = rnw_ff;
    nxt_addr     = addr_ff;
    nxt_cnt      = cnt_ff;
    nxt_sr       = sr_ff;
    nxt_rd_data  = rd_data_ff;
    nxt_rd_valid = 1'b0;
    if (FRAME_END) begin
      nxt_state = ST_IDLE;                    // RULE_12
      nxt_cnt   = 3'h0;
    end else if (BYTE_VALID) begin
      case (state_ff)
        ST_IDLE: begin
          if (BYTE_DATA[7:1] == DEV_ADDR) begin // RULE_10
            nxt_rnw   = BYTE_DATA[0];
            nxt_state = ST_AHI;
          end else nxt_state = ST_SKIP;       // other device
        end
        ST_AHI: begin
          nxt_addr  = {BYTE_DATA[3:0], 8'h00};
          nxt_state = ST_ALO;
        end
        ST_ALO: begin
          nxt_addr[7:0] = BYTE_DATA;
          nxt_cnt       = 3'h0;
          nxt_state     = ST_DATA;
        end
        ST_DATA: begin
          nxt_sr = wword[31:0];
          if (rnw_ff) begin
            nxt_rd_data  = 8'(rd_word >> {idx, 3'b000});
            nxt_rd_valid = 1'b1;
          end
          if (last) begin
            nxt_cnt  = 3'h0;
            nxt_addr = 12'(addr_ff + 12'h001); // RULE_13
          end else begin
            nxt_cnt = 3'(cnt_ff + 3'h1);
          end
        end
        ST_SKIP: nxt_state = ST_SKIP;         // wait for frame end
        default: nxt_state = ST_IDLE;
      endcase
    end
  end
  // register writes on a complete word
  always_comb begin
    nxt_core   = core_ff;
    nxt_sout0  = sout0_ff;
    nxt_sout1  = sout1_ff;
    nxt_sin    = sin_ff;
    nxt_ramcfg = ramcfg_ff;
    nxt_cap0   = cap0_ff;
    nxt_cap1   = cap1_ff;
    nxt_stolen = 1'b0;
    nxt_swa    = swa_ff;
    nxt_swd    = swd_ff;
    nxt_sla    = sla_ff;
    nxt_sld    = sld_ff;
    nxt_pend   = pend_ff;
    sl_fire    = RAM_IDLE && !stolen_ff && (|pend_ff); // RULE_07
    sl_sel     = 3'h0;
    for (int i = SLOTS - 1; i >= 0; i--) begin
      if (pend_ff[i]) sl_sel = 3'(i);
    end
    if (sl_fire) nxt_pend[sl_sel] = 1'b0;     // RULE_07
    if (commit) begin
      if (addr_ff <= `DCPMA_COEF_LAST) begin
        nxt_stolen = 1'b1;                    // RULE_05
        nxt_swa    = addr_ff[9:0];
        nxt_swd    = wword[27:0];             // RULE_04
      end else if (addr_ff >= `DCPMA_SLD_FIRST && addr_ff <= `DCPMA_SLD_LAST) begin
        nxt_sld[sl_idx]  = wword[27:0];       // RULE_21
        nxt_pend[sl_idx] = 1'b1;              // set wins over copy
      end else if (addr_ff >= `DCPMA_SLA_FIRST && addr_ff <= `DCPMA_SLA_LAST) begin
        nxt_sla[3'(addr_ff - `DCPMA_SLA_FIRST)] = wword[9:0]; // RULE_08 RULE_20
      end else begin
        case (addr_ff)
          `DCPMA_CAP0:      nxt_cap0   = wword[12:0]; // RULE_18 RULE_22
          `DCPMA_CAP1:      nxt_cap1   = wword[12:0]; // RULE_18 RULE_22
          `DCPMA_CORE_CTRL: nxt_core   = wword[15:0]; // RULE_16
          `DCPMA_SOUT0:     nxt_sout0  = wword[15:0]; // RULE_16
          `DCPMA_SOUT1:     nxt_sout1  = wword[15:0]; // RULE_16
          `DCPMA_SIN:       nxt_sin    = wword[7:0];  // RULE_17
          `DCPMA_RAMCFG:    nxt_ramcfg = wword[7:0];  // RULE_17
          default:          nxt_core   = core_ff;     // RULE_23
        endcase
      end
    end
  end
  // state registers
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      state_ff    <= ST_IDLE;
      rnw_ff      <= 1'b0;
      addr_ff     <= 12'h000;
      cnt_ff      <= 3'h0;
      sr_ff       <= 32'h00000000;
      rd_data_ff  <= 8'h00;
      rd_valid_ff <= 1'b0;
      core_ff     <= `DCPMA_REG_RESET;        // RULE_03
      sout0_ff    <= `DCPMA_REG_RESET;
      sout1_ff    <= `DCPMA_REG_RESET;
      sin_ff      <= 8'h00;
      ramcfg_ff   <= 8'h00;
      cap0_ff     <= 13'h0000;
      cap1_ff     <= 13'h0000;
      sla_ff      <= '{default: 10'h000};
      sld_ff      <= '{default: 28'h0000000};
      pend_ff     <= '0;
      stolen_ff   <= 1'b0;
      swa_ff      <= 10'h000;
      swd_ff      <= 28'h0000000;
    end else begin
      state_ff    <= nxt_state;
      rnw_ff      <= nxt_rnw;
      addr_ff     <= nxt_addr;
      cnt_ff      <= nxt_cnt;
      sr_ff       <= nxt_sr;
      rd_data_ff  <= nxt_rd_data;
      rd_valid_ff <= nxt_rd_valid;
      core_ff     <= nxt_core;
      sout0_ff    <= nxt_sout0;
      sout1_ff    <= nxt_sout1;
      sin_ff      <= nxt_sin;
      ramcfg_ff   <= nxt_ramcfg;
      cap0_ff     <= nxt_cap0;
      cap1_ff     <= nxt_cap1;
      sla_ff      <= nxt_sla;
      sld_ff      <= nxt_sld;
      pend_ff     <= nxt_pend;
      stolen_ff   <= nxt_stolen;
      swa_ff      <= nxt_swa;
      swd_ff      <= nxt_swd;
    end
  end
  // memory ports; core read holds while the host owns the RAM
  always_ff @(posedge MCLK) begin
    if (stolen_ff) begin
      coef_ram[swa_ff] <= {`DCPMA_COEF_PAD, swd_ff};  // RULE_04 RULE_05
    end else if (sl_fire) begin
      coef_ram[sla_ff[sl_sel]] <= {`DCPMA_COEF_PAD, sld_ff[sl_sel]}; // RULE_07 RULE_08
    end
    if (commit && addr_ff > `DCPMA_COEF_LAST && addr_ff <= `DCPMA_INSTR_LAST) begin
      instr_ram[addr_ff[9:0]] <= wword;       // RULE_02 RULE_15
    end
    if (SRST) begin
      CORE_COEF_DATA  <= 32'h00000000;
      CORE_INSTR_DATA <= 40'h0000000000;
    end else begin
      if (!stolen_ff) CORE_COEF_DATA <= coef_ram[CORE_COEF_ADDR]; // RULE_05
      CORE_INSTR_DATA <= instr_ram[CORE_INSTR_ADDR];
    end
  end
  // outputs straight from flops
  assign RD_DATA                 = rd_data_ff;
  assign RD_VALID                = rd_valid_ff;
  assign COEF_RAM_STOLEN         = stolen_ff;
  assign CAPTURE_PROGRAM_COUNT_0 = cap0_ff[12:2];
  assign CAPTURE_SOURCE_SELECT_0 = cap0_ff[1:0];
  assign CAPTURE_PROGRAM_COUNT_1 = cap1_ff[12:2];
  assign CAPTURE_SOURCE_SELECT_1 = cap1_ff[1:0];
  assign CORE_CONTROL            = core_ff;
  assign SERIAL_OUT_0            = sout0_ff;
  assign SERIAL_OUT_1            = sout1_ff;
  assign SERIAL_IN_CTRL          = sin_ff;
  assign RAM_CONFIG              = ramcfg_ff;
  // header then two address bytes reach the data phase
  sequence s_hdr;
    state_ff == ST_IDLE && BYTE_VALID && !FRAME_END && BYTE_DATA[7:1] == DEV_ADDR;
  endsequence
  sequence s_addr2;
    BYTE_VALID && !FRAME_END ##1 BYTE_VALID && !FRAME_END;
  endsequence
  AST_HEADER: assert property (s_hdr ##1 s_addr2 |=> state_ff == ST_DATA) // RULE_10
    else $error("header did not open data phase");
  AST_WORD_LEN: assert property (commit |-> cnt_ff == 3'(nb - 3'h1)) // RULE_10
    else $error("word committed at wrong byte count");
  AST_INCR: assert property (commit |=> addr_ff == 12'($past(addr_ff) + 12'h001)) // RULE_13
    else $error("burst address did not increment");
  AST_END: assert property (FRAME_END |=> state_ff == ST_IDLE && cnt_ff == 3'h0) // RULE_12
    else $error("frame end did not return to idle");
  AST_STEAL: assert property (commit && addr_ff <= `DCPMA_COEF_LAST |=> COEF_RAM_STOLEN ##1 !COEF_RAM_STOLEN || $past(commit)) // RULE_05
    else $error("direct write did not take the RAM");
  AST_PAD: assert property (CORE_COEF_DATA[31:28] == 4'h0) // RULE_04
    else $error("coefficient pad bits not zero");
  AST_SLOT_COPY: assert property (sl_fire && !commit |=> $countones(pend_ff) < $countones($past(pend_ff))) // RULE_07
    else $error("pending slot not copied");
  AST_SLOT_HOLD: assert property (!RAM_IDLE |=> (~pend_ff & $past(pend_ff)) == '0) // RULE_07
    else $error("slot copied while RAM busy");
  AST_UNMAPPED: assert property (state_ff == ST_DATA && rnw_ff && BYTE_VALID && !FRAME_END && rd_word == 40'h0 |=> RD_VALID && RD_DATA == 8'h00) // RULE_23
    else $error("unmapped read not zero");
  AST_RESET: assert property (@(posedge MCLK) disable iff (1'b0) SRST |=> !RD_VALID && pend_ff == '0 && CORE_CONTROL == 16'h0000) // RULE_03
    else $error("reset values wrong");
endmodule // dcpma_top

// ---- test/dcpma_host.sv ----
// host controller model: sends frame bytes, collects read bytes
module dcpma_host #(
  parameter logic [6:0] DEV_ADDR = 7'h34  // select address of the device
) (
  input  wire logic       MCLK,
  output logic            BYTE_VALID,
  output logic      [7:0] BYTE_DATA,
  output logic            FRAME_END,
  input  wire logic [7:0] RD_DATA,
  input  wire logic       RD_VALID
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] rq[$];  // read bytes in arrival order
  // bus idle at time zero
  initial begin
    BYTE_VALID = 1'b0;
    BYTE_DATA  = 8'h00;
    FRAME_END  = 1'b0;
  end
  // take each read byte in its one valid cycle
  always @(posedge MCLK) begin
    if (RD_VALID === 1'b1) begin
      rq.push_back(RD_DATA);
    end
  end
  // one byte per cycle, back to back
  task automatic put_byte(input logic [7:0] b);
    @(negedge MCLK);
    BYTE_VALID = 1'b1;
    BYTE_DATA  = b;
  endtask
  // header: select address with direction flag, then 12-bit target
  task automatic start(input logic [6:0] dev, input logic rw, input logic [11:0] addr);
    put_byte({dev, rw});
    put_byte({4'h0, addr[11:8]});
    put_byte(addr[7:0]);
  endtask
  // one zero-padded word, most significant byte first
  task automatic put(input int n, input logic [39:0] w);
    for (int i = n - 1; i >= 0; i--) begin
      put_byte(w[8*i +: 8]);
    end
  endtask
  // release the byte line (inverse of last value) and close the frame
  task automatic finish();
    @(negedge MCLK);
    BYTE_VALID = 1'b0;
    BYTE_DATA  = ~BYTE_DATA;
    FRAME_END  = 1'b1;
    @(negedge MCLK);
    FRAME_END  = 1'b0;
  endtask
  // whole write frame of one word
  task automatic wr(input logic [11:0] addr, input int n, input logic [39:0] w);
    start(DEV_ADDR, 1'b0, addr);
    put(n, w);
    finish();
  endtask
  // read frame: dummy bytes clock the answer out
  task automatic rd(input logic [11:0] addr, input int n, output logic [39:0] v);
    rq.delete();
    start(DEV_ADDR, 1'b1, addr);
    put(n, 40'h0);
    finish();
    v = (rq.size() == n) ? 40'h0 : 'x;
    foreach (rq[i]) begin
      v = {v[31:0], rq[i]};
    end
  endtask
endmodule // dcpma_host

// ---- test/dcpma_top_test.sv ----
// self-checking bench for the control port frame decoder
module dcpma_top_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [6:0]  DEV  = 7'h34;           // arbitrary select address
  localparam logic [39:0] IDEF = 40'h00000000a5;  // arbitrary default program word
  logic MCLK, SRST, BYTE_VALID, FRAME_END, RD_VALID, RAM_IDLE, COEF_RAM_STOLEN;
  logic [7:0]  BYTE_DATA, RD_DATA, SERIAL_IN_CTRL, RAM_CONFIG;
  logic [9:0]  CORE_COEF_ADDR, CORE_INSTR_ADDR;
  logic [31:0] CORE_COEF_DATA;
  logic [39:0] CORE_INSTR_DATA;
  logic [23:0] CAPTURE_VALUE_0, CAPTURE_VALUE_1;
  logic [10:0] CAPTURE_PROGRAM_COUNT_0, CAPTURE_PROGRAM_COUNT_1;
  logic [1:0]  CAPTURE_SOURCE_SELECT_0, CAPTURE_SOURCE_SELECT_1;
  logic [15:0] CORE_CONTROL, SERIAL_OUT_0, SERIAL_OUT_1;
  logic [39:0] v, w;      // read-back and peek values
  int n_errors, n_checks; // mismatches and comparisons
  int n_stolen, cyc;      // steal pulses seen, cycles run
  logic [11:0] ra[5] = '{12'h81c, 12'h81e, 12'h81f, 12'h820, 12'h821};
  int          rn[5] = '{2, 2, 2, 1, 1};
  logic [15:0] rv[5] = '{16'h1234, 16'hbeef, 16'h0ff1, 16'h005a, 16'h00a5};

  dcpma_top #(.DEV_ADDR(DEV), .SLOTS(5), .INSTR_DEFAULT(IDEF)) u_dut (.*);
  dcpma_host #(.DEV_ADDR(DEV)) u_host (.MCLK(MCLK), .BYTE_VALID(BYTE_VALID),
    .BYTE_DATA(BYTE_DATA), .FRAME_END(FRAME_END), .RD_DATA(RD_DATA), .RD_VALID(RD_VALID));

  // 100 MHz clock
  initial begin
    MCLK = 1'b0;
    forever #5 MCLK = ~MCLK;
  end
  // count steal pulses; cut a hang short
  always @(posedge MCLK) begin
    n_stolen = n_stolen + ((COEF_RAM_STOLEN === 1'b1) ? 1 : 0);
    cyc = cyc + 1;
    if (cyc == 5000) begin
      n_errors++;
      tally_and_finish();
    end
  end
  // compare one value
  task automatic chk(input logic [39:0] got, input logic [39:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  // core-side look at both RAMs, one cycle latency
  task automatic peek(input logic [9:0] a, output logic [39:0] c, output logic [39:0] i);
    @(negedge MCLK);
    CORE_COEF_ADDR  = a;
    CORE_INSTR_ADDR = a;
    @(negedge MCLK);
    c = {8'h00, CORE_COEF_DATA};
    i = CORE_INSTR_DATA;
  endtask
  // register output by address
  function automatic logic [15:0] regval(input logic [11:0] a);
    case (a)
      12'h81c: regval = CORE_CONTROL;
      12'h81e: regval = SERIAL_OUT_0;
      12'h81f: regval = SERIAL_OUT_1;
      12'h820: regval = {8'h00, SERIAL_IN_CTRL};
      default: regval = {8'h00, RAM_CONFIG};
    endcase
  endfunction
  // counts and verdict
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    SRST = 1'b1;
    RAM_IDLE = 1'b0;
    CORE_COEF_ADDR = 10'h000;
    CORE_INSTR_ADDR = 10'h000;
    CAPTURE_VALUE_0 = 24'h5a1234;
    CAPTURE_VALUE_1 = 24'h0c0ffe;
    n_errors = 0;
    n_checks = 0;
    n_stolen = 0;
    cyc = 0;
    repeat (12) @(negedge MCLK);
    SRST = 1'b0;
    // power-up contents; core control reads zero out of reset
    peek(10'h3ff, v, w);
    chk(v, 40'h0, "coef reset");
    chk(w, IDEF, "instr default");
    chk(CORE_CONTROL, 16'h0, "core reset");
    // direct coefficient write, single steal pulse
    n_stolen = 0;
    u_host.wr(12'h005, 4, 40'h0000800000);
    peek(10'h005, v, w);
    chk(v, 40'h0000800000, "coef write");
    chk(n_stolen, 1, "steal count");
    u_host.rd(12'h005, 4, v);
    chk(v, 40'h0000800000, "coef read");
    // burst from last coefficient into first instruction
    n_stolen = 0;
    u_host.start(DEV, 1'b0, 12'h3ff);
    u_host.put(4, 40'h000fedcba9);
    u_host.put(5, 40'h1122334455);
    u_host.finish();
    chk(n_stolen, 1, "instr no steal");
    peek(10'h3ff, v, w);
    chk(v, 40'h000fedcba9, "burst coef");
    peek(10'h000, v, w);
    chk(w, 40'h1122334455, "burst instr");
    u_host.rd(12'h400, 5, v);
    chk(v, 40'h1122334455, "instr read");
    // registers: write, output, read back
    for (int k = 0; k < 5; k++) begin
      u_host.wr(ra[k], rn[k], {24'h0, rv[k]});
      chk(regval(ra[k]), rv[k], "reg output");
      u_host.rd(ra[k], rn[k], v);
      chk(v, {24'h0, rv[k]}, "reg read");
    end
    // wrong select address and a cut-short word change nothing
    u_host.start(7'h35, 1'b0, 12'h81c);
    u_host.put(2, 40'h0000005555);
    u_host.finish();
    chk(CORE_CONTROL, 16'h1234, "wrong select");
    u_host.start(DEV, 1'b0, 12'h81c);
    u_host.put(1, 40'h0000000077);
    u_host.finish();
    chk(CORE_CONTROL, 16'h1234, "partial word");
    // capture setup, burst over both registers, then reads
    u_host.start(DEV, 1'b0, 12'h81a);
    u_host.put(2, 40'h0000001abd);
    u_host.put(2, 40'h0000000003);
    u_host.finish();
    chk(CAPTURE_PROGRAM_COUNT_0, 11'h6af, "cap pc 0");
    chk(CAPTURE_SOURCE_SELECT_0, 2'h1, "cap sel 0");
    chk(CAPTURE_PROGRAM_COUNT_1, 11'h000, "cap pc 1");
    chk(CAPTURE_SOURCE_SELECT_1, 2'h3, "cap sel 1");
    u_host.rd(12'h81a, 3, v);
    chk(v, 40'h00005a1234, "cap read 0");
    u_host.rd(12'h81b, 3, v);
    chk(v, 40'h00000c0ffe, "cap read 1");
    // deferred update waits for an idle RAM
    u_host.wr(12'h815, 2, 40'h0000000010);
    u_host.wr(12'h810, 5, 40'h000abcdef1);
    repeat (5) @(negedge MCLK);
    peek(10'h010, v, w);
    chk(v, 40'h0, "no copy while busy");
    RAM_IDLE = 1'b1;
    repeat (4) @(negedge MCLK);
    peek(10'h010, v, w);
    chk(v, 40'h000abcdef1, "deferred copy");
    // unmapped and write-only places read zero
    u_host.wr(12'h900, 1, 40'h00000000ff);
    u_host.rd(12'h900, 1, v);
    chk(v, 40'h0, "unmapped read");
    u_host.rd(12'h815, 2, v);
    chk(v, 40'h0, "slot read");
    tally_and_finish();
  end
endmodule // dcpma_top_test
